// ---- design/lpc_regs.svh ----
`ifndef LPC_REGS_SVH
`define LPC_REGS_SVH

// word indexes, byte address = index * 4, compared against adr[7:2]
`define LPC_CTRL_IDX        6'h11
`define LPC_IRQ_STATUS_IDX  6'h12
`define LPC_IRQ_MASK_IDX    6'h13
`define LPC_LINE_STATE_IDX  6'h14

// control register field positions
`define LPC_BIT_MANUAL_CAL  6
`define LPC_BIT_AUTO_AUTO_CALIBRATION_DISABLE   5
`define LPC_BIT_CUR_LIMIT   4
`define LPC_BIT_OVL_PROT    3
`define LPC_BIT_BILL_PROT   2
`define LPC_BIT_RX_OVL      1
`define LPC_BIT_BILL_TONE   0

// interrupt status and mask field positions
`define LPC_IRQ_BILL_TONE   0
`define LPC_IRQ_RX_OVL      1
`define LPC_IRQ_OVL_DET     2
`define LPC_IRQ_CAL_DONE    3

// line state field positions
`define LPC_ST_OVL_PROT     0
`define LPC_ST_BILL_PROT    1
`define LPC_ST_CAL_BUSY     2

// reset values and constants
`define LPC_CTRL_RST        8'h00
`define LPC_IRQ_RST         4'h0
`define LPC_SENSE_ALL_ONES  5'h1F
`define LPC_BUS_ZERO        32'h0000_0000

`endif

// ---- design/lpc_pkg.sv ----
package lpc_pkg;
    // dc termination mode select codes
    typedef enum logic [1:0] {
        LPC_TERM_LOW_VOLT   = 2'h0,
        LPC_TERM_LOWER_VOLT = 2'h1,
        LPC_TERM_STANDARD   = 2'h2,
        LPC_TERM_CUR_LIMIT  = 2'h3
    } lpc_term_mode_t;
endpackage

// ---- design/lpc_sticky_bit.sv ----
`timescale 1ns/1ps
module lpc_sticky_bit (
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_flag
);
    import lpc_pkg::*;

    // sticky flag, a set in the clearing cycle wins
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule

// ---- design/lpc_line_protect_ctrl.sv ----
// Behaviour
// R1: reset clears every control register bit to zero.
// R2: writing one to manual calibration bit 6 starts a calibration cycle.
// R3: auto-calibration disable bit 5 set suppresses automatic calibration.
// R4: current-limit bit 4 acts only in current-limiting termination mode.
// R5: current-limit bit set there limits dc termination current below 60 mA.
// R6: off-hook, overload enable, sense all ones: termination off, hook current reduced, flag set.
// R7: host sets overload enable about 25 ms after going off-hook; the testbench sets it 20 clock cycles (about 500 ns) after.
// R8: writing zero to overload enable releases the protected condition.
// R9: off-hook, billing protect enabled, tone flag rising: 800 ohm, pin stops tracking.
// R10: without billing protection event the termination pin tracks the receive input.
// R11: receive overload flag bit 1 sets on excessive input, cleared by written zero.
// R12: billing tone flag bit 0 sets on detected tone, cleared by written zero.
// R13: termination select code 11 is the current-limiting mode.
// R14: host always writes zero to reserved bit 7.
// R15: writing one to a sticky flag leaves it unchanged.
`timescale 1ns/1ps
`include "lpc_regs.svh"
module lpc_line_protect_ctrl (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_srst,
    input  wire logic                    i_wb_cyc,
    input  wire logic                    i_wb_stb,
    input  wire logic                    i_wb_we,
    input  wire logic [7:0]              i_wb_adr,
    input  wire logic [3:0]              i_wb_sel,
    input  wire logic [31:0]             i_wb_dat,
    output logic      [31:0]             o_wb_dat,
    output logic                         o_wb_ack,
    input  wire logic                    i_off_hook,
    input  wire lpc_pkg::lpc_term_mode_t i_termination_mode_select,
    input  wire logic [4:0]              i_loop_voltage_current_sense,
    input  wire logic                    i_rx_overload_event,
    input  wire logic                    i_billing_tone_event,
    input  wire logic                    i_auto_cal_request,
    input  wire logic                    i_cal_done,
    output logic                         o_cal_start,
    output logic                         o_current_limit_active,
    output logic                         o_dc_term_off,
    output logic                         o_hook_current_reduce,
    output logic                         o_dc_termination_pin_track,
    output logic                         o_overload_detected_flag,
    output logic                         o_irq
);
    import lpc_pkg::*;

    logic       manual_calibration_start;
    logic       auto_calibration_disable;
    logic       termination_current_limit_enable;
    logic       overload_protect_enable;
    logic       billing_tone_protect_enable;
    logic       receive_overload_flag;
    logic       billing_tone_detected_flag;
    logic       cal_busy;
    logic       ovl_prot;
    logic       bill_prot;
    logic       btd_prev;
    logic       btd_rise;
    logic       ovl_trip;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [7:0] ctrl_value;
    logic       wb_hit;
    logic       wb_done;
    logic       wr_lane0;
    logic       ctrl_wr;
    logic       mask_wr;
    logic       status_rd;
    logic       manual_launch;
    logic       auto_launch;
    logic [5:0] sticky_set;
    logic [5:0] sticky_clr;
    logic [5:0] sticky_q;

    ////////////////////////////////////////////////////////////////////////
    // bus decode, access completes on the edge that sees ack high
    assign wb_hit    = i_wb_cyc & i_wb_stb;
    assign wb_done   = wb_hit & o_wb_ack;
    assign wr_lane0  = wb_done & i_wb_we & i_wb_sel[0];
    assign ctrl_wr   = wr_lane0 & (i_wb_adr[7:2] == `LPC_CTRL_IDX);
    assign mask_wr   = wr_lane0 & (i_wb_adr[7:2] == `LPC_IRQ_MASK_IDX);
    assign status_rd = wb_done & ~i_wb_we & (i_wb_adr[7:2] == `LPC_IRQ_STATUS_IDX);

    // readable image, reserved bit 7 reads zero
    assign ctrl_value = {1'b0, manual_calibration_start, auto_calibration_disable,
                         termination_current_limit_enable, overload_protect_enable,
                         billing_tone_protect_enable, receive_overload_flag,
                         billing_tone_detected_flag};

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= wb_hit & ~o_wb_ack;
        end
    end

    // read data latched with ack, unmapped words read zero
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_wb_dat <= `LPC_BUS_ZERO;
        end else if (wb_hit & ~o_wb_ack & ~i_wb_we) begin
            if (i_wb_adr[7:2] == `LPC_CTRL_IDX) begin
                o_wb_dat <= {24'h00_0000, ctrl_value};
            end else if (i_wb_adr[7:2] == `LPC_IRQ_STATUS_IDX) begin
                o_wb_dat <= {28'h000_0000, irq_status};
            end else if (i_wb_adr[7:2] == `LPC_IRQ_MASK_IDX) begin
                o_wb_dat <= {28'h000_0000, irq_mask};
            end else if (i_wb_adr[7:2] == `LPC_LINE_STATE_IDX) begin
                o_wb_dat <= {29'h0000_0000, cal_busy, bill_prot, ovl_prot};
            end else begin
                o_wb_dat <= `LPC_BUS_ZERO;
            end
        end else begin
            o_wb_dat <= `LPC_BUS_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // plain control bits, bit 7 is never stored
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            auto_calibration_disable         <= 1'b0; // R1
            termination_current_limit_enable <= 1'b0; // R1
            overload_protect_enable          <= 1'b0; // R1
            billing_tone_protect_enable      <= 1'b0; // R1
        end else if (ctrl_wr) begin
            auto_calibration_disable         <= i_wb_dat[`LPC_BIT_AUTO_AUTO_CALIBRATION_DISABLE];
            termination_current_limit_enable <= i_wb_dat[`LPC_BIT_CUR_LIMIT];
            overload_protect_enable          <= i_wb_dat[`LPC_BIT_OVL_PROT];
            billing_tone_protect_enable      <= i_wb_dat[`LPC_BIT_BILL_PROT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration launch, manual or automatic when not disabled
    assign manual_launch = ctrl_wr & i_wb_dat[`LPC_BIT_MANUAL_CAL] & ~manual_calibration_start; // R2
    assign auto_launch   = i_auto_cal_request & ~auto_calibration_disable & ~cal_busy & ~ctrl_wr; // R3

    // manual bit stays set until the cycle finishes or a control write clears bit 6
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            manual_calibration_start <= 1'b0; // R1
        end else if (ctrl_wr) begin
            manual_calibration_start <= i_wb_dat[`LPC_BIT_MANUAL_CAL]; // R2
        end else if (i_cal_done) begin
            manual_calibration_start <= 1'b0;
        end
    end

    // one-cycle start pulse and busy tracking
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_cal_start <= 1'b0;
            cal_busy    <= 1'b0;
        end else begin
            o_cal_start <= manual_launch | auto_launch; // R2 R3
            if (manual_launch | auto_launch) begin
                cal_busy <= 1'b1;
            end else if (i_cal_done) begin
                cal_busy <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overload and billing tone protection states
    assign ovl_trip = i_off_hook & overload_protect_enable
                      & (i_loop_voltage_current_sense == `LPC_SENSE_ALL_ONES); // R6
    assign btd_rise = billing_tone_detected_flag & ~btd_prev;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ovl_prot <= 1'b0;
        end else if (~overload_protect_enable) begin
            ovl_prot <= 1'b0; // R8
        end else if (ovl_trip) begin
            ovl_prot <= 1'b1; // R6
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            bill_prot <= 1'b0;
            btd_prev  <= 1'b0;
        end else begin
            btd_prev <= billing_tone_detected_flag;
            if (~billing_tone_protect_enable | ~i_off_hook) begin
                bill_prot <= 1'b0;
            end else if (btd_rise) begin
                bill_prot <= 1'b1; // R9
            end
        end
    end

    // registered line-side controls
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_current_limit_active     <= 1'b0;
            o_dc_term_off              <= 1'b0;
            o_hook_current_reduce      <= 1'b0;
            o_dc_termination_pin_track <= 1'b1;
            o_overload_detected_flag   <= 1'b0;
        end else begin
            o_current_limit_active     <= termination_current_limit_enable
                                          & (i_termination_mode_select == LPC_TERM_CUR_LIMIT); // R4 R5 R13
            o_dc_term_off              <= ovl_prot | bill_prot; // R6 R9
            o_hook_current_reduce      <= ovl_prot; // R6
            o_dc_termination_pin_track <= ~bill_prot; // R9 R10
            o_overload_detected_flag   <= ovl_prot; // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: two control-register flags, four interrupt bits
    assign sticky_set = {i_cal_done & cal_busy, ovl_trip & ~ovl_prot,
                         i_rx_overload_event, i_billing_tone_event,
                         i_rx_overload_event, i_billing_tone_event}; // R11 R12
    assign sticky_clr = {status_rd & o_wb_dat[`LPC_IRQ_CAL_DONE],
                         status_rd & o_wb_dat[`LPC_IRQ_OVL_DET],
                         status_rd & o_wb_dat[`LPC_IRQ_RX_OVL],
                         status_rd & o_wb_dat[`LPC_IRQ_BILL_TONE],
                         ctrl_wr & ~i_wb_dat[`LPC_BIT_RX_OVL],
                         ctrl_wr & ~i_wb_dat[`LPC_BIT_BILL_TONE]}; // R11 R12 R15

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_sticky
            lpc_sticky_bit u_flag (
                .i_sys_clk (i_sys_clk),
                .i_srst    (i_srst),
                .i_set     (sticky_set[gi]),
                .i_clr     (sticky_clr[gi]),
                .o_flag    (sticky_q[gi])
            );
        end
    endgenerate

    assign billing_tone_detected_flag = sticky_q[0];
    assign receive_overload_flag      = sticky_q[1];
    assign irq_status                 = sticky_q[5:2];

    // interrupt mask and level output
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            irq_mask <= `LPC_IRQ_RST;
            o_irq    <= 1'b0;
        end else begin
            if (mask_wr) begin
                irq_mask <= i_wb_dat[3:0];
            end
            o_irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    property p_reset_clear;
        $fell(i_srst) |-> (ctrl_value == `LPC_CTRL_RST) && !o_cal_start;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("control not zero after reset"); // R1

    property p_manual_start;
        manual_launch |=> o_cal_start ##1 cal_busy;
    endproperty
    a_manual_start: assert property (p_manual_start) else $error("manual calibration not started"); // R2

    property p_auto_disabled;
        (auto_calibration_disable && !ctrl_wr) |=> !o_cal_start;
    endproperty
    a_auto_disabled: assert property (p_auto_disabled) else $error("auto calibration not suppressed"); // R3

    property p_cur_limit;
        ##1 o_current_limit_active == $past(termination_current_limit_enable
                                      && i_termination_mode_select == LPC_TERM_CUR_LIMIT);
    endproperty
    a_cur_limit: assert property (p_cur_limit) else $error("current limit mismatch"); // R4 R5 R13

    property p_ovl_trip;
        (ovl_trip && !ctrl_wr) |=> ##1 (o_dc_term_off && o_hook_current_reduce && o_overload_detected_flag);
    endproperty
    a_ovl_trip: assert property (p_ovl_trip) else $error("overload protection not applied"); // R6

    property p_ovl_release;
        !overload_protect_enable |=> ##1 !o_hook_current_reduce;
    endproperty
    a_ovl_release: assert property (p_ovl_release) else $error("overload protection not released"); // R8

    property p_bill_trip;
        (i_off_hook && billing_tone_protect_enable && btd_rise) |=> ##1 (!o_dc_termination_pin_track && o_dc_term_off);
    endproperty
    a_bill_trip: assert property (p_bill_trip) else $error("billing protection not applied"); // R9

    property p_track_normal;
        !bill_prot |=> o_dc_termination_pin_track;
    endproperty
    a_track_normal: assert property (p_track_normal) else $error("pin not tracking receive input"); // R10

    property p_rov_set;
        i_rx_overload_event |=> receive_overload_flag
                                ##1 (receive_overload_flag || $past(ctrl_wr && !i_wb_dat[`LPC_BIT_RX_OVL]));
    endproperty
    a_rov_set: assert property (p_rov_set) else $error("receive overload flag lost"); // R11

    property p_btd_set;
        i_billing_tone_event |=> billing_tone_detected_flag;
    endproperty
    a_btd_set: assert property (p_btd_set) else $error("billing tone flag lost"); // R12

    property p_write_one_keeps;
        (ctrl_wr && i_wb_dat[`LPC_BIT_RX_OVL] && receive_overload_flag) |=> receive_overload_flag;
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag cleared by a one"); // R15

    c_cal_start: cover property (manual_launch ##1 o_cal_start);
    c_ovl_prot:  cover property (ovl_trip ##2 o_hook_current_reduce);
    c_bill_prot: cover property (btd_rise && billing_tone_protect_enable ##2 !o_dc_termination_pin_track);
    c_irq:       cover property ($rose(o_irq));
endmodule

// ---- tb/lpc_host_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// system-side host: classic wishbone master reaching the register over the link
module lpc_host_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_rdat,
    output logic             o_cyc,
    output logic             o_stb,
    output logic             o_we,
    output logic [7:0]       o_adr,
    output logic [3:0]       o_sel,
    output logic [31:0]      o_wdat
);
    logic hung = 1'b0;
    // idle bus from time zero
    initial begin
        o_cyc  = 1'b0;
        o_stb  = 1'b0;
        o_we   = 1'b0;
        o_adr  = 8'h00;
        o_sel  = 4'h0;
        o_wdat = 32'h0000_0000;
    end
    // one access, held until ack is sampled high; bounded wait flags a hang
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        o_cyc  <= 1'b1;
        o_stb  <= 1'b1;
        o_we   <= w;
        o_adr  <= a;
        o_sel  <= 4'hF;
        o_wdat <= {24'h00_0000, 1'b0, d[6:0]};
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (i_ack !== 1'b1 && n < 20);
        hung = (i_ack !== 1'b1);
        r = i_rdat;
        o_cyc  <= 1'b0;
        o_stb  <= 1'b0;
        o_wdat <= ~o_wdat; // stale data not left on the bus
    endtask
endmodule

// ---- tb/tb_lpc_line_protect_ctrl.sv ----
`timescale 1ns/1ps
`include "lpc_regs.svh"
module tb_lpc_line_protect_ctrl;
    import lpc_pkg::*;
    logic           sys_clk = 1'b0;
    logic           srst    = 1'b1;
    logic           cyc, stb, we, ack, irq, cal_start, lim_act, term_off, hook_red, track, ovl_flag;
    logic           hook = 1'b0, rx_ev = 1'b0, bill_ev = 1'b0, acal = 1'b0, cdone = 1'b0;
    logic [4:0]     sense = 5'h00;
    lpc_term_mode_t mode = LPC_TERM_LOW_VOLT;
    logic [7:0]     adr;
    logic [3:0]     sel;
    logic [31:0]    wdat, rdat, v;
    int             n_errors = 0, checks_done = 0, k;
    ////////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #12.5 sys_clk = ~sys_clk;
    lpc_host_model u_lpc_host_model (.i_sys_clk(sys_clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc),
        .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_wdat(wdat));
    lpc_line_protect_ctrl u_lpc_line_protect_ctrl (.i_sys_clk(sys_clk), .i_srst(srst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_off_hook(hook), .i_termination_mode_select(mode),
        .i_loop_voltage_current_sense(sense), .i_rx_overload_event(rx_ev), .i_billing_tone_event(bill_ev),
        .i_auto_cal_request(acal), .i_cal_done(cdone), .o_cal_start(cal_start),
        .o_current_limit_active(lim_act), .o_dc_term_off(term_off), .o_hook_current_reduce(hook_red),
        .o_dc_termination_pin_track(track), .o_overload_detected_flag(ovl_flag), .o_irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rw(input logic w, input logic [5:0] idx, input logic [7:0] d);
        u_lpc_host_model.access(w, {idx, 2'b00}, d, v);
        if (u_lpc_host_model.hung) begin
            $display("mismatch bus ack expected 1 seen 0");
            n_errors++;
            close_out();
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // one-cycle event: 0 rx overload, 1 billing tone, 2 auto cal request, 3 cal done
    task automatic pulse(input int s);
        @(posedge sys_clk);
        {rx_ev, bill_ev, acal, cdone} <= 4'h8 >> s;
        @(posedge sys_clk);
        {rx_ev, bill_ev, acal, cdone} <= 4'h0;
    endtask
    task automatic starts(input int n);
        k = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if (cal_start === 1'b1) k++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rw(1'b0, `LPC_CTRL_IDX, 8'h00);
        check("ctrl reset", v, 32'h0000_0000);
        check("pin track", {31'h0, track}, 32'h1);
        rw(1'b0, 6'h00, 8'h00);
        check("unmapped read", v, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_cal();
        rw(1'b1, `LPC_CTRL_IDX, 8'h43);
        starts(4);
        check("manual start", k, 1);
        rw(1'b1, `LPC_CTRL_IDX, 8'h43);
        starts(4);
        check("repeat start", k, 0);
        pulse(3);
        settle(2);
        rw(1'b0, `LPC_CTRL_IDX, 8'h00);
        check("cal bit done", v, 32'h0000_0000);
        pulse(2);
        starts(3);
        check("auto start", k, 1);
        pulse(3); // finish the auto run so busy cannot hide the disable
        rw(1'b1, `LPC_CTRL_IDX, 8'h23);
        pulse(2);
        starts(3);
        check("auto disabled", k, 0);
        $display("test calibration done");
    endtask
    task automatic t_limit();
        rw(1'b1, `LPC_CTRL_IDX, 8'h13);
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            mode <= lpc_term_mode_t'(m[1:0]);
            settle(3);
            check("limit by mode", {31'h0, lim_act}, {31'h0, m == 3});
        end
        rw(1'b1, `LPC_CTRL_IDX, 8'h03);
        settle(3);
        check("limit off", {31'h0, lim_act}, 32'h0);
        $display("test current limit done");
    endtask
    task automatic t_overload();
        hook <= 1'b1;
        sense <= 5'h1E;
        settle(20);
        rw(1'b1, `LPC_CTRL_IDX, 8'h0B);
        settle(4);
        check("no trip", {29'h0, term_off, hook_red, ovl_flag}, 32'h0);
        @(posedge sys_clk);
        sense <= 5'h1F;
        settle(4);
        check("trip", {29'h0, term_off, hook_red, ovl_flag}, 32'h7);
        rw(1'b0, `LPC_LINE_STATE_IDX, 8'h00);
        check("state", v & 32'h1, 32'h1);
        rw(1'b1, `LPC_CTRL_IDX, 8'h03);
        settle(4);
        check("release", {29'h0, term_off, hook_red, ovl_flag}, 32'h0);
        @(posedge sys_clk);
        sense <= 5'h00;
        $display("test overload done");
    endtask
    task automatic t_billing();
        rw(1'b1, `LPC_CTRL_IDX, 8'h07);
        pulse(1);
        settle(4);
        check("bill protect", {30'h0, term_off, track}, 32'h2);
        rw(1'b0, `LPC_CTRL_IDX, 8'h00);
        check("tone flag", v, 32'h0000_0005);
        rw(1'b1, `LPC_CTRL_IDX, 8'h03);
        settle(4);
        check("bill release", {30'h0, term_off, track}, 32'h1);
        rw(1'b1, `LPC_CTRL_IDX, 8'h02);
        rw(1'b0, `LPC_CTRL_IDX, 8'h00);
        check("tone cleared", v, 32'h0000_0000);
        hook <= 1'b0;
        $display("test billing done");
    endtask
    task automatic t_flags_irq();
        rw(1'b0, `LPC_IRQ_STATUS_IDX, 8'h00);
        check("status all", v, 32'h0000_000D);
        rw(1'b1, `LPC_IRQ_MASK_IDX, 8'h00);
        pulse(0);
        settle(3);
        check("masked irq", {31'h0, irq}, 32'h0);
        rw(1'b0, `LPC_CTRL_IDX, 8'h00);
        check("rx flag", v, 32'h0000_0002);
        rw(1'b1, `LPC_CTRL_IDX, 8'h03);
        rw(1'b0, `LPC_CTRL_IDX, 8'h00);
        check("rx flag kept", v, 32'h0000_0002);
        rw(1'b1, `LPC_IRQ_MASK_IDX, 8'h02);
        settle(3);
        check("irq high", {31'h0, irq}, 32'h1);
        rw(1'b0, `LPC_IRQ_STATUS_IDX, 8'h00);
        check("status", v, 32'h0000_0002);
        settle(3);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rw(1'b1, `LPC_CTRL_IDX, 8'h01);
        rw(1'b0, `LPC_CTRL_IDX, 8'h00);
        check("rx flag cleared", v, 32'h0000_0000);
        $display("test flags and interrupt done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_cal();
        t_limit();
        t_overload();
        t_billing();
        t_flags_irq();
        close_out();
    end
endmodule
